// >>> logic/cmfi_defs.vh
// register offsets, field positions, reset values and timing figures for the flag block
`ifndef CMFI_DEFS_VH
`define CMFI_DEFS_VH
`define CMFI_CLK_MHZ 250
`define CMFI_TICK_US 1
`define CMFI_TICK_DIV (`CMFI_CLK_MHZ * `CMFI_TICK_US)
`define CMFI_T_FLAG_MS 200
`define CMFI_T_LOS_MS 100
`define CMFI_T_MASK_MS 100
`define CMFI_T_RATE_MS 100
`define CMFI_T_PDN_ON_MS 100
`define CMFI_T_PDN_OFF_MS 300
`define CMFI_T_INT_OFF_US 500
`define CMFI_T_FLAG_TK (`CMFI_T_FLAG_MS * 1000 / `CMFI_TICK_US)
`define CMFI_T_LOS_TK (`CMFI_T_LOS_MS * 1000 / `CMFI_TICK_US)
`define CMFI_T_CTL_TK (`CMFI_T_MASK_MS * 1000 / `CMFI_TICK_US)
`define CMFI_T_PDN_OFF_TK (`CMFI_T_PDN_OFF_MS * 1000 / `CMFI_TICK_US)
`define CMFI_NFLAG 8
`define CMFI_FLAG_NOTREADY 0
`define CMFI_FLAG_LOS 1
`define CMFI_FLAG_TXFAULT 2
`define CMFI_ADDR_STATUS 12'h000
`define CMFI_ADDR_MASK 12'h004
`define CMFI_ADDR_CTRL 12'h008
`define CMFI_ADDR_STATE 12'h00c
`define CMFI_CTRL_RATE 0
`define CMFI_CTRL_PDN 1
`define CMFI_CTRL_STOP 2
`define CMFI_MASK_RST 8'hff
`define CMFI_CTRL_RST 3'h0
`endif

// >>> logic/cmfi_delay.v
// bounded-time follower: output adopts a changed input after a programmed number of ticks
`timescale 1ns/1ns
module cmfi_delay #(
  parameter CW = 20,
  parameter [0:0] RST_VAL = 1'b0
) (
  input wire clk_i,
  input wire rst_i,
  input wire tick_i,
  input wire start_i,
  input wire target_i,
  input wire [CW-1:0] rise_tk_i,
  input wire [CW-1:0] fall_tk_i,
  output reg out_o,
  output wire busy_o
);
  reg [CW-1:0] cnt_q;
  reg tgt_q;
  reg run_q;
  assign busy_o = run_q;
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= {CW{1'b0}};
      tgt_q <= RST_VAL;
      run_q <= 1'b0;
      out_o <= RST_VAL;
    end else if (start_i && target_i != out_o) begin
      tgt_q <= target_i;
      run_q <= 1'b1;
      cnt_q <= target_i ? rise_tk_i : fall_tk_i;
    end else if (start_i) begin
      run_q <= 1'b0;
    end else if (run_q && tick_i) begin
      if (cnt_q <= {{(CW-1){1'b0}}, 1'b1}) begin
        out_o <= tgt_q;
        run_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// >>> logic/cmfi_top.v
// flag, mask, interrupt and control timing block with an AXI4-Lite register slave
`timescale 1ns/1ns
`include "cmfi_defs.vh"

// Function
// - tx fault sets its flag and drives interrupt low within 200 ms
// - any other condition sets its flag and interrupt within 200 ms
// - setting a mask bit inhibits that flag's interrupt within 100 ms
// - clearing a mask bit restores that flag's interrupt within 100 ms
// - rate select change reaches the datapath within 100 ms
// - power-down set lowers power within 100 ms
// - power-down cleared makes the device fully functional within 300 ms
// - write-triggered timing starts at the write's stop point
// - fully functional means not-ready cleared and interrupt raised for it; leaving power-down raises FULLY_FUNCTIONAL_O with no such interrupt
// - receive loss sets its flag and interrupt within 100 ms
// - reading flags clears them; interrupt released within 500 us
module cmfi_top #(
  parameter NF = `CMFI_NFLAG,
  parameter TICK_DIV = `CMFI_TICK_DIV,
  parameter T_CTL_TK = `CMFI_T_CTL_TK,
  parameter T_OFF_TK = `CMFI_T_PDN_OFF_TK
) (
  input wire CLK_I,
  input wire RST_I,
  input wire [NF-1:0] COND_I,
  input wire READY_I,
  input wire [11:0] AWADDR_I,
  input wire AWVALID_I,
  output wire AWREADY_O,
  input wire [31:0] WDATA_I,
  input wire [3:0] WSTRB_I,
  input wire WVALID_I,
  output wire WREADY_O,
  output reg [1:0] BRESP_O,
  output reg BVALID_O,
  input wire BREADY_I,
  input wire [11:0] ARADDR_I,
  input wire ARVALID_I,
  output wire ARREADY_O,
  output reg [31:0] RDATA_O,
  output reg [1:0] RRESP_O,
  output reg RVALID_O,
  input wire RREADY_I,
  output reg INTERRUPT_OUT_N_O,
  output wire RATE_SEL_O,
  output wire POWER_DOWN_O,
  output wire FULLY_FUNCTIONAL_O
);
  // ****************************************
  // tick divider
  // ****************************************
  reg [15:0] div_q;
  reg tick_q;
  always @(posedge CLK_I) begin
    if (RST_I) begin
      div_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (div_q == TICK_DIV[15:0] - 16'h0001) begin
      div_q <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  reg aw_q;
  reg w_q;
  reg [11:0] awa_q;
  reg [31:0] wd_q;
  reg [3:0] ws_q;
  assign AWREADY_O = !aw_q && !BVALID_O;
  assign WREADY_O = !w_q && !BVALID_O;
  wire aw_ok = aw_q || (AWVALID_I && AWREADY_O);
  wire w_ok = w_q || (WVALID_I && WREADY_O);
  wire [11:0] wa = aw_q ? awa_q : AWADDR_I;
  wire [31:0] wd = w_q ? wd_q : WDATA_I;
  wire [3:0] ws = w_q ? ws_q : WSTRB_I;
  wire wr_do = aw_ok && w_ok && !BVALID_O;
  wire wr_map = (wa == `CMFI_ADDR_MASK) || (wa == `CMFI_ADDR_CTRL) ||
                (wa == `CMFI_ADDR_STATUS) || (wa == `CMFI_ADDR_STATE);
  always @(posedge CLK_I) begin
    if (RST_I) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 12'h000;
      wd_q <= 32'h00000000;
      ws_q <= 4'h0;
      BVALID_O <= 1'b0;
      BRESP_O <= 2'h0;
    end else begin
      if (wr_do) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        BVALID_O <= 1'b1;
        BRESP_O <= wr_map ? 2'h0 : 2'h3;
      end else begin
        if (AWVALID_I && AWREADY_O) begin
          aw_q <= 1'b1;
          awa_q <= AWADDR_I;
        end
        if (WVALID_I && WREADY_O) begin
          w_q <= 1'b1;
          wd_q <= WDATA_I;
          ws_q <= WSTRB_I;
        end
        if (BVALID_O && BREADY_I) begin
          BVALID_O <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // mask and control registers
  // ****************************************
  localparam [NF-1:0] MASK_RST = `CMFI_MASK_RST;
  reg [NF-1:0] mask_q;
  reg [2:0] ctrl_q;
  // completion of the write stands for the stop point of the serial write
  wire wr_mask = wr_do && wa == `CMFI_ADDR_MASK && ws[0];
  wire wr_ctrl = wr_do && wa == `CMFI_ADDR_CTRL && ws[0];
  always @(posedge CLK_I) begin
    if (RST_I) begin
      mask_q <= MASK_RST;
      ctrl_q <= `CMFI_CTRL_RST;
    end else begin
      if (wr_mask) begin
        mask_q <= wd[NF-1:0];
      end
      if (wr_ctrl) begin
        ctrl_q <= wd[2:0];
      end
    end
  end

  // ****************************************
  // delayed effect of mask and control writes
  // ****************************************
  wire [NF-1:0] mask_eff;
  wire [NF-1:0] mask_busy;
  genvar g;
  generate
    for (g = 0; g < NF; g = g + 1) begin : g_mask
      cmfi_delay #(.CW(20), .RST_VAL(MASK_RST[g])) u_mask (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .tick_i(tick_q),
        .start_i(wr_mask),
        .target_i(wd[g]),
        .rise_tk_i(T_CTL_TK[19:0]),
        .fall_tk_i(T_CTL_TK[19:0]),
        .out_o(mask_eff[g]),
        .busy_o(mask_busy[g])
      );
    end
  endgenerate
  wire rate_busy;
  wire pdn_busy;
  cmfi_delay #(.CW(20)) u_rate (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .tick_i(tick_q),
    .start_i(wr_ctrl),
    .target_i(wd[`CMFI_CTRL_RATE]),
    .rise_tk_i(T_CTL_TK[19:0]),
    .fall_tk_i(T_CTL_TK[19:0]),
    .out_o(RATE_SEL_O),
    .busy_o(rate_busy)
  );
  cmfi_delay #(.CW(20)) u_pdn (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .tick_i(tick_q),
    .start_i(wr_ctrl),
    .target_i(wd[`CMFI_CTRL_PDN]),
    .rise_tk_i(T_CTL_TK[19:0]),
    .fall_tk_i(T_OFF_TK[19:0]),
    .out_o(POWER_DOWN_O),
    .busy_o(pdn_busy)
  );

  // ****************************************
  // flags, clear on read
  // ****************************************
  reg [NF-1:0] flag_q;
  reg [NF-1:0] cond_q;
  reg rdy_q;
  wire rd_status;
  // not-ready deassert is an event on bit 0
  wire [NF-1:0] ev;
  generate
    for (g = 0; g < NF; g = g + 1) begin : g_ev
      if (g == `CMFI_FLAG_NOTREADY) begin : g_nr
        assign ev[g] = READY_I && !rdy_q;
      end else begin : g_c
        assign ev[g] = COND_I[g] && !cond_q[g];
      end
    end
  endgenerate
  always @(posedge CLK_I) begin
    if (RST_I) begin
      flag_q <= {NF{1'b0}};
      cond_q <= {NF{1'b0}};
      rdy_q <= 1'b0;
    end else begin
      cond_q <= COND_I;
      rdy_q <= READY_I;
      // set wins over read clear
      flag_q <= (rd_status ? {NF{1'b0}} : flag_q) | ev;
    end
  end

  // ****************************************
  // readiness and power state
  // ****************************************
  localparam [1:0] PS_WAIT = 2'h0;
  localparam [1:0] PS_FLAG = 2'h1;
  localparam [1:0] PS_RUN = 2'h2;
  localparam [1:0] PS_LOW = 2'h3;
  reg [1:0] ps_q;
  reg [1:0] ps_d;
  always @* begin
    ps_d = ps_q;
    case (ps_q)
      PS_WAIT: begin
        if (ev[`CMFI_FLAG_NOTREADY]) begin
          ps_d = PS_FLAG;
        end
      end
      // one cycle for the interrupt register to take in flag bit 0
      PS_FLAG: begin
        if (!READY_I) begin
          ps_d = PS_WAIT;
        end else if (POWER_DOWN_O || pdn_busy) begin
          ps_d = PS_LOW;
        end else begin
          ps_d = PS_RUN;
        end
      end
      PS_RUN: begin
        if (!READY_I) begin
          ps_d = PS_WAIT;
        end else if (POWER_DOWN_O || pdn_busy) begin
          ps_d = PS_LOW;
        end
      end
      PS_LOW: begin
        if (!READY_I) begin
          ps_d = PS_WAIT;
        end else if (!POWER_DOWN_O && !pdn_busy) begin
          ps_d = PS_RUN;
        end
      end
      default: begin
        ps_d = PS_WAIT;
      end
    endcase
  end
  always @(posedge CLK_I) begin
    if (RST_I) begin
      ps_q <= PS_WAIT;
    end else begin
      ps_q <= ps_d;
    end
  end
  assign FULLY_FUNCTIONAL_O = ps_q == PS_RUN;

  // ****************************************
  // interrupt output
  // ****************************************
  always @(posedge CLK_I) begin
    if (RST_I) begin
      INTERRUPT_OUT_N_O <= 1'b1;
    end else begin
      INTERRUPT_OUT_N_O <= ~|(flag_q & ~mask_eff);
    end
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  assign ARREADY_O = !RVALID_O;
  wire rd_do = ARVALID_I && ARREADY_O;
  assign rd_status = rd_do && ARADDR_I == `CMFI_ADDR_STATUS;
  always @(posedge CLK_I) begin
    if (RST_I) begin
      RVALID_O <= 1'b0;
      RDATA_O <= 32'h00000000;
      RRESP_O <= 2'h0;
    end else if (rd_do) begin
      RVALID_O <= 1'b1;
      RRESP_O <= 2'h0;
      case (ARADDR_I)
        `CMFI_ADDR_STATUS: RDATA_O <= {{(32-NF){1'b0}}, flag_q};
        `CMFI_ADDR_MASK: RDATA_O <= {{(32-NF){1'b0}}, mask_q};
        `CMFI_ADDR_CTRL: RDATA_O <= {29'h0, ctrl_q};
        `CMFI_ADDR_STATE: RDATA_O <= {24'h0, ~INTERRUPT_OUT_N_O, FULLY_FUNCTIONAL_O,
          |mask_busy, rate_busy, pdn_busy, RATE_SEL_O, POWER_DOWN_O, rdy_q};
        default: begin
          RDATA_O <= 32'h00000000;
          RRESP_O <= 2'h3;
        end
      endcase
    end else if (RREADY_I) begin
      RVALID_O <= 1'b0;
    end
  end
endmodule

// >>> tb/cmfi_top_chk.sv
// assertions on the flag block's bus handshakes and timed outputs
`timescale 1ns/1ns
module cmfi_chk #(
  parameter NF = 8,
  parameter TICK_DIV = 2,
  parameter T_CTL_TK = 5,
  parameter T_OFF_TK = 9
) (
  input wire CLK_I,
  input wire RST_I,
  input wire [NF-1:0] COND_I,
  input wire READY_I,
  input wire [11:0] ARADDR_I,
  input wire ARVALID_I,
  input wire ARREADY_O,
  input wire AWREADY_O,
  input wire BVALID_O,
  input wire RVALID_O,
  input wire INTERRUPT_OUT_N_O,
  input wire RATE_SEL_O,
  input wire POWER_DOWN_O,
  input wire FULLY_FUNCTIONAL_O
);
  localparam int LIM_ON = (T_CTL_TK + 2) * TICK_DIV + 4;
  localparam int LIM_OFF = (T_OFF_TK + 2) * TICK_DIV + 4;
  reg [15:0] since_q;
  // ***********************
  // cycles since last write
  // ***********************
  always @(posedge CLK_I) begin
    if (RST_I || BVALID_O) since_q <= 16'h0;
    else if (since_q != 16'hffff) since_q <= since_q + 16'h1;
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_quiet;
    ($stable(COND_I) && $stable(READY_I)) [*3];
  endsequence
  sequence s_status_rd;
    ARVALID_I && ARREADY_O && ARADDR_I == 12'h000;
  endsequence
  chk_int_release: assert property (s_quiet ##0 s_status_rd |=> ##[1:3] INTERRUPT_OUT_N_O)
    else $error("interrupt not released after status read");
  chk_pdn_on_bound: assert property ($rose(POWER_DOWN_O) |-> since_q <= LIM_ON)
    else $error("power down applied too late");
  chk_pdn_off_bound: assert property ($fell(POWER_DOWN_O) |-> since_q <= LIM_OFF)
    else $error("power down released too late");
  chk_rate_bound: assert property ($changed(RATE_SEL_O) |-> since_q <= LIM_ON)
    else $error("rate select applied too late");
  chk_pdn_not_ff: assert property (POWER_DOWN_O |-> !FULLY_FUNCTIONAL_O)
    else $error("fully functional while powered down");
  chk_ff_cause: assert property ($rose(FULLY_FUNCTIONAL_O) |-> READY_I && !POWER_DOWN_O)
    else $error("fully functional without ready");
  chk_read_answer: assert property (ARVALID_I && ARREADY_O |=> RVALID_O && !ARREADY_O)
    else $error("read not answered next cycle");
  chk_write_refused: assert property (BVALID_O |-> !AWREADY_O)
    else $error("write address taken during response");
endmodule
bind cmfi_top cmfi_chk #(.NF(NF), .TICK_DIV(TICK_DIV), .T_CTL_TK(T_CTL_TK), .T_OFF_TK(T_OFF_TK))
  u_cmfi_chk (.CLK_I(CLK_I), .RST_I(RST_I), .COND_I(COND_I), .READY_I(READY_I),
  .ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .AWREADY_O(AWREADY_O),
  .BVALID_O(BVALID_O), .RVALID_O(RVALID_O), .INTERRUPT_OUT_N_O(INTERRUPT_OUT_N_O),
  .RATE_SEL_O(RATE_SEL_O), .POWER_DOWN_O(POWER_DOWN_O), .FULLY_FUNCTIONAL_O(FULLY_FUNCTIONAL_O));

// >>> tb/cmfi_host.sv
// register bus master standing in for the management host
`timescale 1ns/1ns
module cmfi_host (
  input wire clk_i,
  output reg [11:0] awaddr_o,
  output reg awvalid_o,
  input wire awready_i,
  output reg [31:0] wdata_o,
  output wire [3:0] wstrb_o,
  output reg wvalid_o,
  input wire wready_i,
  input wire [1:0] bresp_i,
  input wire bvalid_i,
  output wire bready_o,
  output reg [11:0] araddr_o,
  output reg arvalid_o,
  input wire arready_i,
  input wire [31:0] rdata_i,
  input wire [1:0] rresp_i,
  input wire rvalid_i,
  output wire rready_o
);
  assign wstrb_o = 4'hf;
  assign bready_o = 1'b1;
  assign rready_o = 1'b1;
  initial begin
    awaddr_o = 12'h0; awvalid_o = 1'b0; wdata_o = 32'h0; wvalid_o = 1'b0;
    araddr_o = 12'h0; arvalid_o = 1'b0;
  end
  // ******************************************
  // transfers, entered just after a clock edge
  // ******************************************
  task wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    awaddr_o <= a; awvalid_o <= 1'b1; wdata_o <= d; wvalid_o <= 1'b1;
    do begin
      #3 ta = awvalid_o && awready_i; tw = wvalid_o && wready_i; tb = bvalid_i; r = bresp_i;
      @(posedge clk_i);
      if (ta) awvalid_o <= 1'b0;
      if (tw) wvalid_o <= 1'b0;
    end while (!tb);
  endtask
  task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    araddr_o <= a; arvalid_o <= 1'b1;
    do begin
      #3 ta = arvalid_o && arready_i; tr = rvalid_i; d = rdata_i; r = rresp_i;
      @(posedge clk_i);
      if (ta) arvalid_o <= 1'b0;
    end while (!tr);
  endtask
endmodule

// >>> tb/cmfi_top_bench.sv
// self-checking bench for the flag, mask and control timing block
`timescale 1ns/1ns
`include "cmfi_defs.vh"
module cmfi_top_bench;
  reg CLK_I = 1'b0;
  reg RST_I = 1'b1;
  reg [7:0] COND_I = 8'h0;
  reg READY_I = 1'b0;
  wire [11:0] AWADDR_I, ARADDR_I;
  wire [31:0] WDATA_I, RDATA_O;
  wire [3:0] WSTRB_I;
  wire [1:0] BRESP_O, RRESP_O;
  wire AWVALID_I, AWREADY_O, WVALID_I, WREADY_O, BVALID_O, BREADY_I;
  wire ARVALID_I, ARREADY_O, RVALID_O, RREADY_I;
  wire INTERRUPT_OUT_N_O, RATE_SEL_O, POWER_DOWN_O, FULLY_FUNCTIONAL_O;
  wire [3:0] probe = {FULLY_FUNCTIONAL_O, POWER_DOWN_O, RATE_SEL_O, INTERRUPT_OUT_N_O};
  int failures = 0;
  int checks_done = 0;
  logic [31:0] d;
  logic [1:0] r;
  always #2 CLK_I = ~CLK_I;
  cmfi_top #(.TICK_DIV(2), .T_CTL_TK(5), .T_OFF_TK(9)) u_cmfi_top (.CLK_I(CLK_I), .RST_I(RST_I),
    .COND_I(COND_I), .READY_I(READY_I), .AWADDR_I(AWADDR_I), .AWVALID_I(AWVALID_I),
    .AWREADY_O(AWREADY_O), .WDATA_I(WDATA_I), .WSTRB_I(WSTRB_I), .WVALID_I(WVALID_I),
    .WREADY_O(WREADY_O), .BRESP_O(BRESP_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I),
    .ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O),
    .RRESP_O(RRESP_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I),
    .INTERRUPT_OUT_N_O(INTERRUPT_OUT_N_O), .RATE_SEL_O(RATE_SEL_O),
    .POWER_DOWN_O(POWER_DOWN_O), .FULLY_FUNCTIONAL_O(FULLY_FUNCTIONAL_O));
  cmfi_host u_cmfi_host (.clk_i(CLK_I), .awaddr_o(AWADDR_I), .awvalid_o(AWVALID_I),
    .awready_i(AWREADY_O), .wdata_o(WDATA_I), .wstrb_o(WSTRB_I), .wvalid_o(WVALID_I),
    .wready_i(WREADY_O), .bresp_i(BRESP_O), .bvalid_i(BVALID_O), .bready_o(BREADY_I),
    .araddr_o(ARADDR_I), .arvalid_o(ARVALID_I), .arready_i(ARREADY_O), .rdata_i(RDATA_O),
    .rresp_i(RRESP_O), .rvalid_i(RVALID_O), .rready_o(RREADY_I));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // waits a bounded number of cycles for one probed output to reach a level
  task wt(input int s, input logic v, input int n);
    int i;
    i = 0;
    #1;
    while (probe[s] !== v && i < n) begin
      @(posedge CLK_I); #1; i++;
    end
    chk(probe[s], v);
    @(posedge CLK_I);
  endtask
  task give_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // **************
  // test sequence
  // **************
  initial begin
    repeat (3) @(posedge CLK_I);
    RST_I <= 1'b0;
    @(posedge CLK_I);
    u_cmfi_host.rd(`CMFI_ADDR_MASK, d, r); chk(d, 32'hff);
    u_cmfi_host.rd(`CMFI_ADDR_CTRL, d, r); chk(d, 32'h0);
    u_cmfi_host.rd(12'h010, d, r); chk(r, 2'h3);
    u_cmfi_host.wr(12'h020, 32'h0, r); chk(r, 2'h3);
    COND_I[2] <= 1'b1;
    repeat (6) @(posedge CLK_I);
    wt(0, 1'b1, 0);
    u_cmfi_host.wr(`CMFI_ADDR_MASK, 32'h0, r); chk(r, 2'h0);
    wt(0, 1'b0, 30);
    u_cmfi_host.rd(`CMFI_ADDR_STATUS, d, r); chk(d, 32'h4);
    wt(0, 1'b1, 4);
    COND_I[1] <= 1'b1; wt(0, 1'b0, 6);
    u_cmfi_host.rd(`CMFI_ADDR_STATUS, d, r); chk(d, 32'h2);
    wt(0, 1'b1, 4);
    READY_I <= 1'b1; wt(0, 1'b0, 6);
    wt(3, 1'b1, 4);
    u_cmfi_host.rd(`CMFI_ADDR_STATUS, d, r); chk(d, 32'h1);
    u_cmfi_host.wr(`CMFI_ADDR_MASK, 32'h4, r); chk(r, 2'h0);
    repeat (30) @(posedge CLK_I);
    COND_I[2] <= 1'b0;
    @(posedge CLK_I);
    COND_I[2] <= 1'b1;
    repeat (6) @(posedge CLK_I);
    wt(0, 1'b1, 0);
    u_cmfi_host.rd(`CMFI_ADDR_STATUS, d, r); chk(d, 32'h4);
    u_cmfi_host.wr(`CMFI_ADDR_CTRL, 32'h1, r); wt(1, 1'b1, 30);
    u_cmfi_host.wr(`CMFI_ADDR_CTRL, 32'h3, r); wt(2, 1'b1, 30);
    wt(3, 1'b0, 0);
    u_cmfi_host.wr(`CMFI_ADDR_CTRL, 32'h1, r); wt(2, 1'b0, 40);
    wt(3, 1'b1, 40);
    u_cmfi_host.rd(`CMFI_ADDR_STATE, d, r); chk(d, 32'h45);
    give_verdict;
  end
  initial begin
    #40000;
    failures++;
    give_verdict;
  end
endmodule
